//--- inc/bcir_pkg.sv
// constants and types for the boot configuration and identification register bank
package bcir_pkg;
	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;
	// own registers
	localparam logic [15:0] ADDR_BOOT_CTRL = 16'h0000;
	localparam logic [15:0] ADDR_BOOT_MEM = 16'h0001;
	localparam logic [15:0] ADDR_IDENT_0 = 16'h0002;
	localparam logic [15:0] ADDR_IDENT_1 = 16'h0003;
	localparam logic [15:0] ADDR_IDENT_2 = 16'h0004;
	localparam logic [15:0] ADDR_CFG_LOW = 16'h0005;
	localparam logic [15:0] ADDR_BOOT_STAT = 16'h021E;
	// block boundaries, first address of each block; BLK_END is one past the last and is not used by the decode
	localparam logic [15:0] BLK_SERIAL = 16'h0006;
	localparam logic [15:0] BLK_DPLL0 = 16'h0008;
	localparam logic [15:0] BLK_DPLL1 = 16'h003B;
	localparam logic [15:0] BLK_RSVD_LO = 16'h00C9;
	localparam logic [15:0] BLK_IRQ_STAT = 16'h0200;
	localparam logic [15:0] BLK_GLOBAL = 16'h021A;
	localparam logic [15:0] BLK_RSVD_HI = 16'h0220;
	localparam logic [15:0] BLK_END = 16'h0400;
	// field positions
	localparam int RETRY_LSB = 3;
	localparam int RETRY_W = 5;
	localparam int SKIP_OTP_BIT = 1;
	localparam int SKIP_EXT_BIT = 0;
	localparam int TWO_BYTE_BIT = 7;
	localparam int BOOT_MEMORY_BUS_ADDRESS_W = 7;
	localparam int BOOT_FAIL_BIT = 0;
	localparam logic [4:0] RETRY_RESET = 5'h01;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	typedef enum logic [2:0] {
		BCIR_RGN_OWN,
		BCIR_RGN_SERIAL,
		BCIR_RGN_DPLL0,
		BCIR_RGN_OTHER,
		BCIR_RGN_GLOBAL,
		BCIR_RGN_RSVD
	} bcir_region_t;
	typedef enum {
		BCIR_ST_POWERUP,
		BCIR_ST_OTP,
		BCIR_ST_EXT,
		BCIR_ST_READY
	} bcir_state_t;
endpackage

//--- verilog/bcir_regs.sv
// boot configuration and identification register bank with boot sequencing
`timescale 1ns/1ps
module bcir_regs
	import bcir_pkg::*;
#(
	parameter logic [7:0] DEF_BOOT_CTRL = 8'h08,
	parameter logic [7:0] DEF_BOOT_MEM_ADDR = 8'h50,
	// arbitrary identification values
	parameter logic [3:0] DEF_REVISION = 4'h5,
	parameter logic [15:0] DEF_PART_CODE = 16'h1234,
	parameter logic [10:0] DEF_CFG_CODE = 11'h000
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_i,
	// byte register port from the serial slave
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [15:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	output logic [7:0] host_rdata_o,
	output logic host_rvalid_o,
	output logic host_busy_o,
	// forwarding to other register blocks
	input wire logic [7:0] ext_rdata_i,
	output logic ext_wr_o,
	output logic [15:0] ext_addr_o,
	output logic [7:0] ext_wdata_o,
	output bcir_region_t ext_region_o,
	// power-up and one-time memory loader
	input wire logic powerup_done_i,
	input wire logic otp_done_i,
	output logic otp_start_o,
	output logic otp_full_load_o,
	// external memory boot engine
	input wire logic boot_wr_i,
	input wire logic [15:0] boot_addr_i,
	input wire logic [7:0] boot_wdata_i,
	input wire logic boot_done_i,
	input wire logic boot_abort_i,
	output logic boot_start_o,
	output logic [4:0] arbitration_retry_count_o,
	output logic two_byte_offset_mode_o,
	output logic [6:0] boot_memory_bus_address_o,
	output logic boot_load_failed_o
);
	logic [7:0] ctrl_reg, ctrl_next;
	logic [7:0] eep_reg, eep_next;
	logic [7:0] id0_reg, id0_next;
	logic [7:0] id1_reg, id1_next;
	logic [7:0] id2_reg, id2_next;
	logic [7:0] cfg_reg, cfg_next;
	logic fail_reg, fail_next;
	bcir_state_t state_reg, state_next;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic otp_start_reg, otp_start_next;
	logic boot_start_reg, boot_start_next;
	logic ext_wr_reg, ext_wr_next;
	logic [15:0] ext_addr_reg, ext_addr_next;
	logic [7:0] ext_wdata_reg, ext_wdata_next;
	logic busy;
	logic host_wr_ok;
	logic host_rd_ok;
	bcir_region_t region;

	// address to register block
	function automatic bcir_region_t decode(input logic [15:0] a);
		bcir_region_t r;
		r = BCIR_RGN_RSVD;
		if (a < BLK_SERIAL) begin
			r = BCIR_RGN_OWN;
		end else if (a < BLK_DPLL0) begin
			r = BCIR_RGN_SERIAL;
		end else if (a < BLK_DPLL1) begin
			r = BCIR_RGN_DPLL0;
		end else if (a < BLK_RSVD_LO) begin
			r = BCIR_RGN_OTHER;
		end else if (a < BLK_IRQ_STAT) begin
			r = BCIR_RGN_RSVD;
		end else if (a < BLK_GLOBAL) begin
			r = BCIR_RGN_OTHER;
		end else if (a < BLK_RSVD_HI) begin
			r = BCIR_RGN_GLOBAL;
		end else begin
			r = BCIR_RGN_RSVD;
		end
		return r;
	endfunction

	assign region = decode(host_addr_i);
	assign busy = (state_reg != BCIR_ST_READY);
	assign host_wr_ok = host_wr_i && !busy;
	assign host_rd_ok = host_rd_i && !busy;

	// boot sequencing
	always_comb begin
		state_next = state_reg;
		otp_start_next = 1'b0;
		boot_start_next = 1'b0;
		fail_next = fail_reg;
		unique case (state_reg)
			BCIR_ST_POWERUP: begin
				if (powerup_done_i) begin
					state_next = BCIR_ST_OTP;
					otp_start_next = 1'b1;
				end
			end
			BCIR_ST_OTP: begin
				if (otp_done_i) begin
					if (!ctrl_reg[SKIP_EXT_BIT]) begin
						state_next = BCIR_ST_EXT;
						boot_start_next = 1'b1;
					end else begin
						state_next = BCIR_ST_READY;
					end
				end
			end
			BCIR_ST_EXT: begin
				if (boot_abort_i) begin
					state_next = BCIR_ST_READY;
				end else if (boot_done_i) begin
					state_next = BCIR_ST_READY;
				end
			end
			BCIR_ST_READY: begin
				state_next = BCIR_ST_READY;
			end
		endcase
		// write one clears; a new abort wins over the clear
		if (host_wr_ok && host_addr_i == ADDR_BOOT_STAT && host_wdata_i[BOOT_FAIL_BIT]) begin
			fail_next = 1'b0;
		end
		if (state_reg == BCIR_ST_EXT && boot_abort_i) begin
			fail_next = 1'b1;
		end
	end

	// own register writes
	always_comb begin
		ctrl_next = ctrl_reg;
		eep_next = eep_reg;
		id0_next = id0_reg;
		id1_next = id1_reg;
		id2_next = id2_reg;
		cfg_next = cfg_reg;
		if (host_wr_ok && region == BCIR_RGN_OWN) begin
			unique case (host_addr_i)
				ADDR_BOOT_CTRL: ctrl_next = host_wdata_i;
				ADDR_BOOT_MEM: eep_next = host_wdata_i;
				ADDR_IDENT_0: id0_next = host_wdata_i;
				ADDR_IDENT_1: id1_next = host_wdata_i;
				ADDR_IDENT_2: id2_next = host_wdata_i;
				ADDR_CFG_LOW: cfg_next = host_wdata_i;
				default: ctrl_next = ctrl_reg;
			endcase
		end
	end

	// read path and forwarding
	always_comb begin
		rdata_next = ZERO_BYTE;
		rvalid_next = host_rd_i;
		ext_wr_next = 1'b0;
		ext_addr_next = ext_addr_reg;
		ext_wdata_next = ext_wdata_reg;
		if (host_rd_ok) begin
			unique case (region)
				BCIR_RGN_OWN: begin
					unique case (host_addr_i)
						ADDR_BOOT_CTRL: rdata_next = ctrl_reg;
						ADDR_BOOT_MEM: rdata_next = eep_reg;
						ADDR_IDENT_0: rdata_next = id0_reg;
						ADDR_IDENT_1: rdata_next = id1_reg;
						ADDR_IDENT_2: rdata_next = id2_reg;
						ADDR_CFG_LOW: rdata_next = cfg_reg;
						default: rdata_next = ZERO_BYTE;
					endcase
				end
				BCIR_RGN_GLOBAL: begin
					if (host_addr_i == ADDR_BOOT_STAT) begin
						rdata_next = ext_rdata_i;
						rdata_next[BOOT_FAIL_BIT] = fail_reg;
					end else begin
						rdata_next = ext_rdata_i;
					end
				end
				BCIR_RGN_RSVD: rdata_next = ZERO_BYTE;
				default: rdata_next = ext_rdata_i;
			endcase
		end
		if (busy && boot_wr_i) begin
			ext_wr_next = 1'b1;
			ext_addr_next = boot_addr_i;
			ext_wdata_next = boot_wdata_i;
		end else if (host_wr_ok && region != BCIR_RGN_OWN && region != BCIR_RGN_RSVD) begin
			ext_wr_next = 1'b1;
			ext_addr_next = host_addr_i;
			ext_wdata_next = host_wdata_i;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (rst_i) begin
			state_reg <= BCIR_ST_POWERUP;
			ctrl_reg <= {RETRY_RESET, DEF_BOOT_CTRL[RETRY_LSB-1:0]};
			eep_reg <= DEF_BOOT_MEM_ADDR;
			id0_reg <= {DEF_REVISION, DEF_PART_CODE[15:12]};
			id1_reg <= DEF_PART_CODE[11:4];
			id2_reg <= {DEF_PART_CODE[3:0], DEF_CFG_CODE[10:7]};
			cfg_reg <= {DEF_CFG_CODE[6:0], 1'b0};
			fail_reg <= 1'b0;
			rdata_reg <= ZERO_BYTE;
			rvalid_reg <= 1'b0;
			otp_start_reg <= 1'b0;
			boot_start_reg <= 1'b0;
			ext_wr_reg <= 1'b0;
			ext_addr_reg <= '0;
			ext_wdata_reg <= ZERO_BYTE;
		end else begin
			state_reg <= state_next;
			ctrl_reg <= ctrl_next;
			eep_reg <= eep_next;
			id0_reg <= id0_next;
			id1_reg <= id1_next;
			id2_reg <= id2_next;
			cfg_reg <= cfg_next;
			fail_reg <= fail_next;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			otp_start_reg <= otp_start_next;
			boot_start_reg <= boot_start_next;
			ext_wr_reg <= ext_wr_next;
			ext_addr_reg <= ext_addr_next;
			ext_wdata_reg <= ext_wdata_next;
		end
	end

	assign host_rdata_o = rdata_reg;
	assign host_rvalid_o = rvalid_reg;
	assign host_busy_o = busy;
	assign ext_wr_o = ext_wr_reg;
	assign ext_addr_o = ext_addr_reg;
	assign ext_wdata_o = ext_wdata_reg;
	assign ext_region_o = region;
	assign otp_start_o = otp_start_reg;
	assign otp_full_load_o = !ctrl_reg[SKIP_OTP_BIT];
	assign boot_start_o = boot_start_reg;
	assign arbitration_retry_count_o = ctrl_reg[RETRY_LSB +: RETRY_W];
	assign two_byte_offset_mode_o = eep_reg[TWO_BYTE_BIT];
	assign boot_memory_bus_address_o = eep_reg[BOOT_MEMORY_BUS_ADDRESS_W-1:0];
	assign boot_load_failed_o = fail_reg;
endmodule // bcir_regs

//--- tb/bcir_boot_model.sv
// loader and boot engine stand-in for the register bank
`timescale 1ns/1ps
module bcir_boot_model (
	// clock, reset, start pulses and failure mode select
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic otp_start_o,
	input wire logic boot_start_o,
	input wire logic fail_mode,
	// loader answers
	output logic powerup_done_i = 1'h0,
	output logic otp_done_i = 1'h0,
	output logic boot_done_i = 1'h0,
	output logic boot_abort_i = 1'h0,
	output int starts = 0
);
	logic [2:0] o_sh = 3'h0;
	logic [2:0] b_sh = 3'h0;
	always @(posedge clk_sys_i) begin
		powerup_done_i <= !rst_i;
		o_sh <= {o_sh[1:0], otp_start_o};
		b_sh <= {b_sh[1:0], boot_start_o};
		otp_done_i <= o_sh[1];
		boot_done_i <= b_sh[2] && !fail_mode;
		boot_abort_i <= b_sh[2] && fail_mode;
		starts <= rst_i ? 0 : starts + int'(boot_start_o);
	end
endmodule // bcir_boot_model

//--- tb/bcir_regs_sva.sv
// assertions on the register bank ports
`timescale 1ns/1ps
module bcir_regs_sva
	import bcir_pkg::*;
(
	// clock, reset, host port
	input wire logic clk_sys_i,
	input wire logic rst_i,
	input wire logic host_wr_i,
	input wire logic host_rd_i,
	input wire logic [15:0] host_addr_i,
	input wire logic [7:0] host_wdata_i,
	input wire logic [7:0] host_rdata_o,
	input wire logic host_rvalid_o,
	input wire logic host_busy_o,
	// forwarding and boot
	input wire logic ext_wr_o,
	input wire logic [15:0] ext_addr_o,
	input wire logic boot_abort_i,
	input wire logic otp_full_load_o,
	input wire logic [4:0] arbitration_retry_count_o,
	input wire logic two_byte_offset_mode_o,
	input wire logic [6:0] boot_memory_bus_address_o,
	input wire logic boot_load_failed_o
);
	wire logic wr_ok = host_wr_i && !host_busy_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (rst_i);
	read_answer_a: assert property (host_rd_i |=> host_rvalid_o)
		else $error("read not answered");
	retry_write_a: assert property (wr_ok && host_addr_i == 16'h0000 |=>
		arbitration_retry_count_o == $past(host_wdata_i[7:3])
		&& otp_full_load_o == !$past(host_wdata_i[1])) else $error("byte zero fields");
	eep_write_a: assert property (wr_ok && host_addr_i == 16'h0001 |=>
		{two_byte_offset_mode_o, boot_memory_bus_address_o} == $past(host_wdata_i))
		else $error("byte one fields");
	busy_drop_a: assert property (host_busy_o && host_wr_i |=>
		$stable(arbitration_retry_count_o)) else $error("write taken while busy");
	rsvd_read_a: assert property (host_rd_i && !host_busy_o && host_addr_i inside
		{[16'h00c9:16'h01ff], [16'h0220:16'hffff]} |=> host_rdata_o == 8'h00)
		else $error("reserved read not zero");
	ext_fwd_a: assert property (wr_ok && host_addr_i inside
		{[16'h0006:16'h00c8], [16'h0200:16'h021d]} |=> ext_wr_o
		&& ext_addr_o == $past(host_addr_i)) else $error("write not forwarded");
	fail_set_a: assert property ($rose(boot_load_failed_o) |-> $past(boot_abort_i))
		else $error("failure flag without abort");
	fail_hold_a: assert property (boot_load_failed_o && !(wr_ok
		&& host_addr_i == 16'h021e && host_wdata_i[0]) |=> boot_load_failed_o)
		else $error("failure flag lost");
endmodule // bcir_regs_sva
bind bcir_regs bcir_regs_sva bcir_regs_sva_inst (.*);

//--- tb/bcir_regs_bench.sv
// self-checking bench for the boot configuration register bank
`timescale 1ns/1ps
module bcir_regs_bench;
	import bcir_pkg::*;
	logic clk_sys_i = 0, rst_i = 1, host_wr_i = 0, host_rd_i = 0, fail_mode = 1, boot_wr_i = 0;
	logic [15:0] host_addr_i = 16'h0000, boot_addr_i = 16'h0000, ext_addr_o;
	logic [7:0] host_wdata_i = 8'h00, ext_rdata_i = 8'h5a, boot_wdata_i = 8'h00;
	logic [7:0] host_rdata_o, ext_wdata_o, d;
	logic host_rvalid_o, host_busy_o, ext_wr_o, powerup_done_i, otp_done_i, otp_start_o;
	logic otp_full_load_o, boot_done_i, boot_abort_i, boot_start_o, two_byte_offset_mode_o;
	logic boot_load_failed_o;
	logic [4:0] arbitration_retry_count_o;
	logic [6:0] boot_memory_bus_address_o;
	bcir_region_t ext_region_o;
	int errors = 0, tests_run = 0, starts;
	bcir_regs bcir_regs_inst (.*);
	bcir_boot_model bcir_boot_model_inst (.*);
	initial forever #5 clk_sys_i = ~clk_sys_i;
	task finish_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		tests_run++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask
	task acc(input logic w, input logic [15:0] a, input logic [7:0] v);
		@(negedge clk_sys_i);
		{host_wr_i, host_rd_i, host_addr_i, host_wdata_i} = {w, !w, a, v};
		@(negedge clk_sys_i);
		{host_wr_i, host_rd_i, d} = {2'h0, host_rdata_o};
		if (!w) chk("rvalid", host_rvalid_o, 16'h0001);
	endtask
	task rd(input logic [15:0] a, input logic [7:0] e);
		acc(0, a, 8'h00);
		chk("rdata", d, e);
	endtask
	task boot(input logic f);
		int i;
		fail_mode = f;
		rst_i = 1;
		repeat (16) @(negedge clk_sys_i);
		rst_i = 0;
		acc(1, 16'h0000, 8'h00);
		{boot_wr_i, boot_addr_i, boot_wdata_i} = {1'b1, 16'h0008, 8'h77};
		@(negedge clk_sys_i);
		boot_wr_i = 0;
		chk("boot write", ext_wr_o, 16'h0001);
		chk("boot addr", ext_addr_o, 16'h0008);
		chk("boot data", ext_wdata_o, 16'h0077);
		for (i = 0; i < 60 && host_busy_o !== 1'b0; i++) @(negedge clk_sys_i);
		if (i == 60) begin
			errors++;
			finish_test;
		end
		chk("fail", boot_load_failed_o, f);
		chk("retry", arbitration_retry_count_o, 16'h0001);
		chk("address", boot_memory_bus_address_o, 16'h0050);
		chk("full load", otp_full_load_o, 16'h0001);
		chk("boot reads", starts, 16'h0001);
	endtask
	task t_ident;
		rd(16'h0002, 8'h51);
		rd(16'h0003, 8'h23);
		rd(16'h0004, 8'h40);
		rd(16'h0005, 8'h00);
		acc(1, 16'h0005, 8'hfe);
		rd(16'h0005, 8'hfe);
	endtask
	task t_map;
		rd(16'h00c9, 8'h00);
		acc(1, 16'h0300, 8'hff);
		rd(16'h0300, 8'h00);
		rd(16'h0010, 8'h5a);
		rd(16'h021b, 8'h5a);
		acc(1, 16'h0006, 8'h10);
		chk("ext write", ext_wr_o, 16'h0001);
		chk("ext addr", ext_addr_o, 16'h0006);
		chk("region", ext_region_o, BCIR_RGN_SERIAL);
		chk("ext data", ext_wdata_o, 16'h0010);
	endtask
	task t_startup;
		acc(1, 16'h0000, 8'hfa);
		chk("retry", arbitration_retry_count_o, 16'h001f);
		chk("full load", otp_full_load_o, 16'h0000);
		acc(1, 16'h0001, 8'hab);
		chk("offset mode", two_byte_offset_mode_o, 16'h0001);
		chk("address", boot_memory_bus_address_o, 16'h002b);
		rd(16'h0000, 8'hfa);
		rd(16'h021e, 8'h5b);
		acc(1, 16'h021e, 8'h01);
		chk("fail clear", boot_load_failed_o, 16'h0000);
		rd(16'h021e, 8'h5a);
	endtask
	initial begin
		boot(1);
		t_ident;
		t_map;
		t_startup;
		boot(0);
		finish_test;
	end
endmodule // bcir_regs_bench
